// file: verilog/dmhp_pkg.sv
`default_nettype none
package dmhp_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int SYNC_STAGES = 3;
  // Bus style encodings on the select pin
  localparam logic STYLE_STROBE = 1'h0;
  localparam logic STYLE_DIRLINE = 1'h1;
  // Direction line level meaning read
  localparam logic DIR_READ = 1'h1;
  // Host clock 250 MHz, RAM clock window bounds in MHz
  localparam int CLK_MHZ = 250;
  localparam int RAM_CLK_MIN_MHZ = 19;
  localparam int RAM_CLK_MAX_MHZ = 35;
  // Arbiter slot enable; divide rounded up so the slot rate never passes the maximum
  localparam int ARB_DIV = (CLK_MHZ + RAM_CLK_MAX_MHZ - 1) / RAM_CLK_MAX_MHZ;
  localparam int ARB_DIV_W = 4;
  // Last divider count; the slot enable fires when div_reg reaches it
  localparam logic [ARB_DIV_W-1:0] ARB_DIV_LAST = 4'(ARB_DIV - 1);
  // Host idle time after a cycle, long enough for the far synchroniser to see select high
  localparam logic [3:0] HOST_REC_LAST = 4'h7;
  typedef enum logic [4:0]
  {
    DS_IDLE = 5'h01,
    DS_WAIT = 5'h02,
    DS_GRANT = 5'h04,
    DS_DONE = 5'h08,
    DS_END = 5'h10
  } dmhp_dev_state_t;
  typedef enum logic [2:0]
  {
    HS_IDLE = 3'h1,
    HS_ACTIVE = 3'h2,
    HS_RECOVER = 3'h4
  } dmhp_host_state_t;
endpackage
`default_nettype wire

// file: verilog/dmhp_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dmhp_bus_if;
  import dmhp_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_host_o;
  logic data_host_oe;
  logic [DATA_W-1:0] data_dev_o;
  logic data_dev_oe;
  logic [DATA_W-1:0] data;
  logic wr_strobe_n;
  logic rd_dir;
  logic select_n;
  logic bus_style_select;
  logic transfer_handshake_o;
  logic transfer_handshake_oe;
  logic transfer_handshake;
  logic irq_o;
  logic irq_oe;
  logic irq_line;
  // Wire resolution: pull-ups where nothing drives
  assign data = data_dev_oe ? data_dev_o : (data_host_oe ? data_host_o : 8'hFF);
  assign transfer_handshake = transfer_handshake_oe ? transfer_handshake_o : 1'h1;
  // Interrupt pulls to its inactive level, which depends on the style
  assign irq_line = irq_oe ? irq_o : bus_style_select;
  modport dev
  (
    input addr, data, wr_strobe_n, rd_dir, select_n, bus_style_select,
    output data_dev_o, data_dev_oe, transfer_handshake_o, transfer_handshake_oe,
    output irq_o, irq_oe
  );
  modport host
  (
    output addr, data_host_o, data_host_oe, wr_strobe_n, rd_dir, select_n,
    output bus_style_select,
    input data, transfer_handshake, irq_line
  );
endinterface
`default_nettype wire

// file: verilog/dmhp_sync.sv
`timescale 1ns/1ns
`default_nettype none
module dmhp_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import dmhp_pkg::*;
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;
  // Accept a change only once stages two and three agree
  always_comb
  begin
    out_next = out_reg;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_reg[i] == s3_reg[i])
        out_next[i] = s3_reg[i];
    end
  end
  // Stage one feeds only stage two
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      out_reg <= '1;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end
  assign sync_out = out_reg;
endmodule
`default_nettype wire

// file: verilog/dmhp_host_end.sv
`timescale 1ns/1ns
`default_nettype none
module dmhp_host_end
  import dmhp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dmhp_bus_if.host bus,
  input wire logic style_dirline,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic irq_pending
);
  dmhp_host_state_t st_reg, st_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic write_reg, write_next;
  logic rsp_reg, rsp_next;
  logic armed_reg, armed_next;
  logic [3:0] rec_reg, rec_next;
  logic style_reg;
  logic hs_s;
  logic irq_s;
  logic [DATA_W-1:0] data_s;
  logic done;
  // Device pins are foreign to this clock
  dmhp_sync #(.WIDTH(2)) u_sync_ctl
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({bus.transfer_handshake, bus.irq_line}),
    .sync_out({hs_s, irq_s})
  );
  dmhp_sync #(.WIDTH(DATA_W)) u_sync_data
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(bus.data),
    .sync_out(data_s)
  );
  // Ready goes high, acknowledge goes low
  assign done = style_reg ? !hs_s : hs_s;
  always_comb
  begin
    st_next = st_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    write_next = write_reg;
    rsp_next = 1'h0;
    armed_next = armed_reg;
    rec_next = rec_reg;
    case (st_reg)
      HS_IDLE:
      begin
        if (req_valid)
        begin
          addr_next = req_addr;
          wdata_next = req_wdata;
          write_next = req_write;
          armed_next = 1'h0;
          st_next = HS_ACTIVE;
        end
      end
      HS_ACTIVE:
      begin
        // Floating ready reads high, so trust done only after a not-done was seen
        if (!done)
          armed_next = 1'h1;
        // Hold strobes until the device finishes
        if (done && armed_reg)
        begin
          rdata_next = write_reg ? rdata_reg : data_s;
          rsp_next = 1'h1;
          rec_next = '0;
          st_next = HS_RECOVER;
        end
      end
      HS_RECOVER:
      begin
        // Keep select high long enough that the device sees the cycle end
        rec_next = 4'(rec_reg + 1'h1);
        if (rec_reg == HOST_REC_LAST)
          st_next = HS_IDLE;
      end
      default: st_next = HS_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= HS_IDLE;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      write_reg <= 1'h0;
      rsp_reg <= 1'h0;
      armed_reg <= 1'h0;
      rec_reg <= '0;
      style_reg <= STYLE_STROBE;
    end
    else
    begin
      st_reg <= st_next;
      armed_reg <= armed_next;
      rec_reg <= rec_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      write_reg <= write_next;
      rsp_reg <= rsp_next;
      // Style only changes between cycles
      if (st_reg == HS_IDLE)
        style_reg <= style_dirline;
    end
  end
  // Pin drive
  assign bus.addr = addr_reg;
  assign bus.data_host_o = wdata_reg;
  assign bus.data_host_oe = (st_reg == HS_ACTIVE) && write_reg;
  assign bus.select_n = !(st_reg == HS_ACTIVE);
  assign bus.bus_style_select = style_reg;
  // Write strobe low only in strobe mode, high otherwise
  assign bus.wr_strobe_n = !((st_reg == HS_ACTIVE) && write_reg && (style_reg == STYLE_STROBE));
  // Read strobe or direction level
  assign bus.rd_dir = (style_reg == STYLE_DIRLINE) ? !write_reg
    : !((st_reg == HS_ACTIVE) && !write_reg);
  assign req_ready = (st_reg == HS_IDLE);
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
  assign irq_pending = (style_reg == STYLE_DIRLINE) ? !irq_s : irq_s;
endmodule
`default_nettype wire

// file: verilog/dmhp_dev_end.sv
`timescale 1ns/1ns
`default_nettype none
module dmhp_dev_end
  import dmhp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dmhp_bus_if.dev bus,
  input wire logic irq_output_enable,
  input wire logic irq_drive_style,
  input wire logic irq_request,
  output logic mem_host_valid,
  output logic mem_host_write,
  output logic [ADDR_W-1:0] mem_host_addr,
  output logic [DATA_W-1:0] mem_host_wdata,
  input wire logic [DATA_W-1:0] mem_host_rdata,
  input wire logic int_req,
  output logic int_grant
);
  dmhp_dev_state_t st_reg, st_next;
  logic [ARB_DIV_W-1:0] div_reg, div_next;
  logic turn_reg, turn_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic write_reg, write_next;
  logic style_reg, style_next;
  logic sel_s, wr_s, rd_s, style_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic slot;
  logic cyc_on;
  logic cyc_write;
  logic host_turn;
  logic ack_done;
  // Every host pin crosses in before the arbiter looks
  dmhp_sync #(.WIDTH(4)) u_sync_ctl
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({bus.select_n, bus.wr_strobe_n, bus.rd_dir, bus.bus_style_select}),
    .sync_out({sel_s, wr_s, rd_s, style_s})
  );
  dmhp_sync #(.WIDTH(ADDR_W + DATA_W)) u_sync_bus
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({bus.addr, bus.data}),
    .sync_out({addr_s, data_s})
  );
  // Decode a live host cycle per style
  function automatic logic cycle_active(input logic style, input logic sel_n,
                                        input logic wr_n, input logic rd);
    if (sel_n)
      cycle_active = 1'h0;
    else if (style == STYLE_DIRLINE)
      cycle_active = 1'h1;
    else
      cycle_active = !wr_n || !rd;
  endfunction
  assign cyc_on = cycle_active(style_s, sel_s, wr_s, rd_s);
  assign cyc_write = (style_s == STYLE_DIRLINE) ? (rd_s != DIR_READ) : !wr_s;
  // Slot enable at the RAM clock rate drives the arbiter
  assign slot = (div_reg == ARB_DIV_LAST);
  // Host gets the slot on its turn, or whenever internal side is idle
  assign host_turn = turn_reg || !int_req;
  assign int_grant = slot && int_req && !(turn_reg && (st_reg == DS_WAIT));
  always_comb
  begin
    div_next = slot ? '0 : ARB_DIV_W'(div_reg + 1'h1);
    turn_next = turn_reg;
    st_next = st_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    write_next = write_reg;
    style_next = style_reg;
    if (slot)
      turn_next = !turn_reg; // Alternate so neither side starves
    case (st_reg)
      DS_IDLE:
      begin
        if (cyc_on)
        begin
          addr_next = addr_s;
          wdata_next = data_s;
          write_next = cyc_write;
          style_next = style_s;
          st_next = DS_WAIT;
        end
      end
      DS_WAIT:
      begin
        if (slot && host_turn)
          st_next = DS_GRANT;
      end
      DS_GRANT:
      begin
        // RAM answers one cycle after the grant
        rdata_next = mem_host_rdata;
        st_next = DS_DONE;
      end
      DS_DONE:
      begin
        // Hold handshake until host drops the cycle
        if (!cyc_on)
          st_next = DS_END;
      end
      DS_END: st_next = DS_IDLE;
      default: st_next = DS_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= DS_IDLE;
      div_reg <= '0;
      turn_reg <= 1'h0;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      write_reg <= 1'h0;
      style_reg <= STYLE_STROBE;
    end
    else
    begin
      st_reg <= st_next;
      div_reg <= div_next;
      turn_reg <= turn_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      write_reg <= write_next;
      style_reg <= style_next;
    end
  end
  // One-cycle RAM strobe toward internal memory
  assign mem_host_valid = (st_reg == DS_WAIT) && slot && host_turn;
  assign mem_host_write = write_reg;
  assign mem_host_addr = addr_reg;
  assign mem_host_wdata = wdata_reg;
  assign ack_done = (st_reg == DS_DONE);
  // Data out only during a selected read
  assign bus.data_dev_o = rdata_reg;
  assign bus.data_dev_oe = !bus.select_n && !write_reg && ack_done;
  // Ready high when done, ack low when done
  assign bus.transfer_handshake_o = (style_reg == STYLE_DIRLINE) ? !ack_done : ack_done;
  assign bus.transfer_handshake_oe = !bus.select_n;
  // Interrupt level by style
  assign bus.irq_o = (bus.bus_style_select == STYLE_DIRLINE) ? !irq_request : irq_request;
  // Float unless enabled; drive inactive level only in full mode
  assign bus.irq_oe = irq_output_enable && (irq_drive_style || irq_request);
endmodule
`default_nettype wire

// file: verif/dmhp_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module dmhp_asserts
  import dmhp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic wr_strobe_n,
  input wire logic rd_dir,
  input wire logic select_n,
  input wire logic bus_style_select,
  input wire logic data_dev_oe,
  input wire logic transfer_handshake_o,
  input wire logic transfer_handshake_oe,
  input wire logic irq_o,
  input wire logic irq_oe,
  input wire logic irq_output_enable,
  input wire logic irq_drive_style,
  input wire logic irq_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Done level flips with style, so one flag serves both modes
  logic done;
  logic rd;
  assign done = transfer_handshake_oe && (transfer_handshake_o ^ bus_style_select);
  assign rd = rd_dir ^ !bus_style_select;
  sequence s_sel;
    $fell(select_n);
  endsequence
  sequence s_rel;
    $rose(select_n);
  endsequence
  a_done_bound: assert property (s_sel |-> ##[1:60] done)
    else $error("handshake late");
  a_bus_release: assert property (s_rel |-> ##[0:10] !data_dev_oe && !transfer_handshake_oe)
    else $error("bus not released");
  a_read_valid: assert property (done && rd && !select_n |-> data_dev_oe)
    else $error("read done without data");
  a_write_ack: assert property (done && !rd && !select_n |-> !data_dev_oe)
    else $error("data driven on write");
  a_drive_read: assert property ($rose(data_dev_oe) |-> !select_n && rd)
    else $error("data driven outside read");
  a_addr_stable: assert property (!select_n && !$past(select_n) |-> $stable(addr))
    else $error("address moved");
  a_wr_parked: assert property (bus_style_select && !select_n |-> wr_strobe_n)
    else $error("write strobe low in dir mode");
  a_irq_off: assert property (!irq_output_enable |-> !irq_oe)
    else $error("irq driven while disabled");
  a_irq_gate: assert property (irq_output_enable && !irq_drive_style |-> irq_oe == irq_request)
    else $error("irq gating wrong");
  a_irq_full: assert property (irq_output_enable && irq_drive_style |-> irq_oe)
    else $error("irq not driven");
  a_irq_level: assert property (irq_oe |-> irq_o == (irq_request ^ bus_style_select))
    else $error("irq polarity wrong");
endmodule
`default_nettype wire

// file: verif/dual_mode_host_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dual_mode_host_port_tb;
  import dmhp_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic style_dirline = 0;
  logic req_valid = 0;
  logic req_write = 0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic [DATA_W-1:0] mem_host_rdata = '0;
  logic [DATA_W-1:0] rsp_rdata;
  logic req_ready, rsp_valid, int_grant, mem_host_valid, mem_host_write;
  logic irq_pending;
  int cyc = 0;
  int last_slot = -1;
  logic irq_output_enable = 0;
  logic irq_drive_style = 0;
  logic irq_request = 0;
  logic int_req = 0;
  logic [ADDR_W-1:0] mem_host_addr;
  logic [DATA_W-1:0] mem_host_wdata;
  logic [DATA_W-1:0] mm [1024];
  logic [DATA_W-1:0] em [1024];
  logic [DATA_W-1:0] qr [$];
  logic [18:0] qm [$];
  logic [ADDR_W-1:0] ad [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
  int miscompares = 0;
  int n_checks = 0;
  int seed = 37;
  always #2 clk = ~clk;
  dmhp_bus_if dmhp_bus_if_i();
  dmhp_host_end dmhp_host_end_i(.clk, .rst_n, .bus(dmhp_bus_if_i), .style_dirline,
    .req_valid, .req_write, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
    .irq_pending);
  dmhp_dev_end dmhp_dev_end_i(.clk, .rst_n, .bus(dmhp_bus_if_i), .irq_output_enable,
    .irq_drive_style, .irq_request, .mem_host_valid, .mem_host_write, .mem_host_addr,
    .mem_host_wdata, .mem_host_rdata, .int_req, .int_grant);
  dmhp_asserts dmhp_asserts_i(.clk, .rst_n, .addr(dmhp_bus_if_i.addr),
    .wr_strobe_n(dmhp_bus_if_i.wr_strobe_n), .rd_dir(dmhp_bus_if_i.rd_dir),
    .select_n(dmhp_bus_if_i.select_n), .bus_style_select(dmhp_bus_if_i.bus_style_select),
    .data_dev_oe(dmhp_bus_if_i.data_dev_oe), .irq_o(dmhp_bus_if_i.irq_o),
    .transfer_handshake_o(dmhp_bus_if_i.transfer_handshake_o),
    .transfer_handshake_oe(dmhp_bus_if_i.transfer_handshake_oe),
    .irq_oe(dmhp_bus_if_i.irq_oe), .irq_output_enable, .irq_drive_style, .irq_request);
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Idle sampled on the falling edge, away from the launch edge
  task automatic wait_ready();
    int i = 0;
    @(negedge clk);
    while (req_ready !== 1'h1 && i < 400)
    begin
      @(negedge clk);
      i++;
    end
    if (i == 400)
    begin
      miscompares++;
      close_out();
    end
    @(posedge clk);
  endtask
  // Read note pushed after the take edge so a stale pulse cannot claim it
  task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wait_ready();
    if (w)
      em[a] = d;
    qm.push_back({w, a, w ? d : 8'h00});
    req_valid <= 1'h1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'h0;
    if (!w)
      qr.push_back(em[a]);
  endtask
  // Memory stand-in plus scoreboard; internal side competes at random
  always @(posedge clk)
  begin
    int_req <= 1'($random(seed));
    cyc <= cyc + 1;
    // Slot events must fall on a whole number of arbiter periods
    if (mem_host_valid === 1'h1 || int_grant === 1'h1)
    begin
      if (last_slot >= 0)
        chk(19'((cyc - last_slot) % ARB_DIV), 19'h0);
      last_slot <= cyc;
    end
    if (mem_host_valid === 1'h1)
    begin
      mem_host_rdata <= mm[mem_host_addr];
      if (mem_host_write)
        mm[mem_host_addr] <= mem_host_wdata;
      chk({mem_host_write, mem_host_addr, mem_host_write ? mem_host_wdata : 8'h00},
        qm.size() > 0 ? qm.pop_front() : 19'h7FFFF);
      chk({dmhp_bus_if_i.wr_strobe_n, dmhp_bus_if_i.rd_dir}, style_dirline ?
        {1'h1, !mem_host_write} : {!mem_host_write, mem_host_write});
      chk(int_grant, 1'h0);
    end
    if (rsp_valid === 1'h1 && qr.size() > 0)
      chk(rsp_rdata, qr.pop_front());
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    chk(19'(ARB_DIV * RAM_CLK_MAX_MHZ >= CLK_MHZ), 19'h1);
    for (int m = 0; m < 2; m++)
    begin
      style_dirline <= m[0];
      for (int k = 0; k < 8; k++)
        op(k < 4, ad[k % 4], 8'($random(seed)));
      wait_ready();
      repeat (20) @(posedge clk);
      chk(dmhp_bus_if_i.bus_style_select, m[0]);
      chk({dmhp_bus_if_i.data_dev_oe, dmhp_bus_if_i.transfer_handshake_oe}, 2'h0);
      chk(qr.size() + qm.size(), 0);
      for (int c = 0; c < 8; c++)
      begin
        {irq_output_enable, irq_drive_style, irq_request} <= 3'(c);
        repeat (6) @(posedge clk);
        chk({dmhp_bus_if_i.irq_oe, dmhp_bus_if_i.irq_line, irq_pending},
          {c[2] && (c[1] || c[0]), (c[2] && (c[1] || c[0])) ? (c[0] ^ m[0]) : m[0],
          c[2] && c[0]});
      end
      irq_output_enable <= 1'h0;
      $display("pass %0d done", m);
    end
    close_out();
  end
endmodule
`default_nettype wire
